// ==== rtl/rst_wdg_pkg.sv ====
package rst_wdg_pkg;
    // ==========================================================
    // register map
    localparam logic [7:0]  WDG_OFFSET     = 8'hd8;
    localparam logic [7:0]  CAUSE_OFFSET   = 8'hf0;
    localparam logic [7:0]  WDG_RESET      = 8'hfe;
    localparam logic [6:0]  WDG_CNT_RESET  = 7'h7f;
    localparam logic [6:0]  WDG_CNT_EDGE   = 7'h40;
    localparam int          WDG_C_BIT      = 0;
    localparam int          WDG_SR_BIT     = 1;
    localparam int          WDG_T_BASE     = 2;
    localparam int          WDG_T_W        = 6;
    localparam int          WDG_CNT_W      = 7;
    localparam int          CAUSE_EXT      = 0;
    localparam int          CAUSE_POR      = 1;
    localparam int          CAUSE_LVD      = 2;
    localparam int          CAUSE_WDG      = 3;
    localparam int          CAUSE_W        = 4;
    localparam logic [7:0]  ZERO_BYTE      = 8'h00;

    // ==========================================================
    // initialisation values
    localparam logic [11:0] RESET_VECTOR   = 12'hffe;
    localparam logic [7:0]  AR_SC0_RESET   = 8'h02;
    localparam logic [7:0]  TMR_CNT_RESET  = 8'hff;
    localparam logic [7:0]  TMR_PSC_RESET  = 8'h7f;

    // ==========================================================
    // timing defaults, in core clock cycles
    localparam int          WDG_TICK_CYCLES = 3072;
    localparam int          STAB_CYCLES     = 2048;
    localparam int          WDG_PIN_CYCLES  = 16;

    typedef enum logic [2:0] {
        ST_HOLD,
        ST_OSC_WAIT,
        ST_STAB,
        ST_INIT,
        ST_RUN
    } seq_state_e;

    typedef struct packed {
        logic [7:0] ar_sc0;
        logic [7:0] tmr_cnt;
        logic [7:0] tmr_psc;
        logic [7:0] misc;
        logic [7:0] port;
        logic [7:0] intr_opt;
        logic [7:0] spi_ctl;
    } periph_init_s;

    localparam periph_init_s PERIPH_INIT = '{
        ar_sc0:   AR_SC0_RESET,
        tmr_cnt:  TMR_CNT_RESET,
        tmr_psc:  TMR_PSC_RESET,
        misc:     ZERO_BYTE,
        port:     ZERO_BYTE,
        intr_opt: ZERO_BYTE,
        spi_ctl:  ZERO_BYTE
    };
endpackage

// ==== rtl/reset_watchdog_ctrl.sv ====
// Local design decision: the Wishbone register port.
`timescale 1ns/1ps
// Operation
// - four sources reset: pin, power-on, watchdog, low-voltage
// - reset held while pin is low
// - pin reset stretched by internal delay
// - run/wait pin reset: halt, pull-ups, oscillator restart
// - stop pin reset: oscillator start, pull-ups, delay
// - power-on holds reset, pull-ups, no execution
// - stabilisation delay after oscillator, then initialise
// - watchdog end-of-count resets device and counter
// - watchdog reset restarts like pin reset
// - low-voltage detector static reset with hysteresis
// - internal sources drive reset pin low
// - reset clears stack, loads reset vector
// - init runs non-maskable; return restores normal
// - after return, service pending interrupt else continue
// - timer registers get their nonzero reset values
// - misc, port, option, spi control cleared
// - reloadable down-counter, reload defers reset
// - software option: activate bit latches until reset
// - disabled watchdog permits stop mode
// - hardware option: stop acts as wait, counting
// - external stop control: nmi high freezes, stops
// - leaving stop resumes counter from frozen value
// - clearing software reset bit resets immediately
// - register bit order reversed against counter
module reset_watchdog_ctrl #(
    parameter int WDG_TICK = rst_wdg_pkg::WDG_TICK_CYCLES,
    parameter int STAB     = rst_wdg_pkg::STAB_CYCLES,
    parameter int PIN_HOLD = rst_wdg_pkg::WDG_PIN_CYCLES
) (
    input  wire logic                      i_core_clk,
    input  wire logic                      i_reset_n,
    input  wire logic                      i_reset_pin_in_n,
    input  wire logic                      i_por_active,
    input  wire logic                      i_lvd_enable,
    input  wire logic                      i_vdd_above_rise,
    input  wire logic                      i_vdd_above_fall,
    input  wire logic                      i_osc_running,
    input  wire logic                      i_wdg_hw_option,
    input  wire logic                      i_ext_stop_option,
    input  wire logic                      i_nmi_pin,
    input  wire logic                      i_stop_instr,
    input  wire logic                      i_wait_instr,
    input  wire logic                      i_wakeup,
    input  wire logic                      i_return_from_interrupt_instr_instr,
    input  wire logic                      i_irq_pending,
    input  wire logic                      i_wb_cyc,
    input  wire logic                      i_wb_stb,
    input  wire logic                      i_wb_we,
    input  wire logic [7:0]                i_wb_adr,
    input  wire logic [7:0]                i_wb_dat,
    input  wire logic [0:0]                i_wb_sel,
    output logic      [7:0]                o_wb_dat,
    output logic                           o_wb_ack,
    output logic                           o_reset_pin_out,
    output logic                           o_reset_pin_oe,
    output logic                           o_core_reset,
    output logic                           o_io_pullup,
    output logic                           o_osc_enable,
    output logic                           o_stop_mode,
    output logic                           o_wait_mode,
    output logic                           o_stack_clear,
    output logic                           o_pc_load,
    output logic      [11:0]               o_pc_value,
    output logic                           o_nmi_mode,
    output logic                           o_irq_service,
    output logic                           o_next_instr,
    output rst_wdg_pkg::periph_init_s      o_periph_init
);
    localparam int TICK_W = $clog2(WDG_TICK + 1);
    localparam int STAB_W = $clog2(STAB + 1);
    localparam int HOLD_W = $clog2(PIN_HOLD + 1);
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(WDG_TICK - 1);
    localparam logic [STAB_W-1:0] STAB_LAST = STAB_W'(STAB - 1);
    localparam logic [HOLD_W-1:0] HOLD_LOAD = HOLD_W'(PIN_HOLD);
    // ==========================================================
    // pin synchroniser and reset sources
    logic                     pin_meta_r;
    logic                     pin_sync_r;
    logic                     lvd_low_r;
    logic [HOLD_W-1:0]        wdg_hold_r;
    logic                     internal_src;
    logic                     any_src;
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            pin_meta_r <= 1'b0;
            pin_sync_r <= 1'b0;
        end else begin
            pin_meta_r <= i_reset_pin_in_n;
            pin_sync_r <= pin_meta_r;
        end
    end
    // falling threshold below rising one gives hysteresis
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            lvd_low_r <= 1'b1;
        end else if (!i_lvd_enable) begin
            lvd_low_r <= 1'b0;
        end else if (!i_vdd_above_fall) begin
            lvd_low_r <= 1'b1;
        end else if (i_vdd_above_rise) begin
            lvd_low_r <= 1'b0;
        end
    end
    assign internal_src = i_por_active | lvd_low_r | (wdg_hold_r != '0);
    assign any_src      = internal_src | !pin_sync_r;
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            o_reset_pin_oe  <= 1'b0;
            o_reset_pin_out <= 1'b0;
        end else begin
            o_reset_pin_oe  <= internal_src;
            o_reset_pin_out <= 1'b0;
        end
    end
    // ==========================================================
    // reset sequencer
    rst_wdg_pkg::seq_state_e state_r;
    rst_wdg_pkg::seq_state_e state_nxt;
    logic [STAB_W-1:0]       stab_r;
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            rst_wdg_pkg::ST_HOLD: begin
                state_nxt = rst_wdg_pkg::ST_OSC_WAIT;
            end
            rst_wdg_pkg::ST_OSC_WAIT: begin
                if (i_osc_running) begin
                    state_nxt = rst_wdg_pkg::ST_STAB;
                end
            end
            rst_wdg_pkg::ST_STAB: begin
                if (stab_r == STAB_LAST) begin
                    state_nxt = rst_wdg_pkg::ST_INIT;
                end
            end
            rst_wdg_pkg::ST_INIT: begin
                state_nxt = rst_wdg_pkg::ST_RUN;
            end
            rst_wdg_pkg::ST_RUN: begin
                state_nxt = rst_wdg_pkg::ST_RUN;
            end
        endcase
        // every source, watchdog included, restarts the same way
        if (any_src) begin
            state_nxt = rst_wdg_pkg::ST_HOLD;
        end
    end
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            state_r <= rst_wdg_pkg::ST_HOLD;
        end else begin
            state_r <= state_nxt;
        end
    end
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n || state_r != rst_wdg_pkg::ST_STAB) begin
            stab_r <= '0;
        end else begin
            stab_r <= stab_r + 1'b1;
        end
    end
    // ==========================================================
    // core-facing controls
    logic stop_nxt;
    logic wait_nxt;
    logic wdg_en;
    logic stop_ok;
    assign stop_ok = !wdg_en || (i_ext_stop_option && i_nmi_pin);
    always_comb begin
        stop_nxt = o_stop_mode;
        wait_nxt = o_wait_mode;
        if (state_nxt != rst_wdg_pkg::ST_RUN) begin
            stop_nxt = 1'b0;
            wait_nxt = 1'b0;
        end else if (i_wakeup) begin
            stop_nxt = 1'b0;
            wait_nxt = 1'b0;
        end else if (i_stop_instr && !o_stop_mode && !o_wait_mode) begin
            stop_nxt = stop_ok;
            wait_nxt = !stop_ok;
        end else if (i_wait_instr && !o_stop_mode && !o_wait_mode) begin
            wait_nxt = 1'b1;
        end
    end
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            o_core_reset <= 1'b1;
            o_io_pullup  <= 1'b1;
            o_osc_enable <= 1'b1;
            o_stop_mode  <= 1'b0;
            o_wait_mode  <= 1'b0;
        end else begin
            o_core_reset <= state_nxt != rst_wdg_pkg::ST_RUN;
            o_io_pullup  <= state_nxt != rst_wdg_pkg::ST_RUN;
            o_osc_enable <= !stop_nxt;
            o_stop_mode  <= stop_nxt;
            o_wait_mode  <= wait_nxt;
        end
    end
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            o_stack_clear <= 1'b0;
            o_pc_load     <= 1'b0;
            o_pc_value    <= rst_wdg_pkg::RESET_VECTOR;
            o_periph_init <= rst_wdg_pkg::PERIPH_INIT;
        end else begin
            o_stack_clear <= state_nxt == rst_wdg_pkg::ST_INIT;
            o_pc_load     <= state_nxt == rst_wdg_pkg::ST_INIT;
            o_pc_value    <= rst_wdg_pkg::RESET_VECTOR;
            o_periph_init <= rst_wdg_pkg::PERIPH_INIT;
        end
    end
    // init routine cannot be interrupted until its return
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            o_nmi_mode    <= 1'b1;
            o_irq_service <= 1'b0;
            o_next_instr  <= 1'b0;
        end else if (state_nxt != rst_wdg_pkg::ST_RUN) begin
            o_nmi_mode    <= 1'b1;
            o_irq_service <= 1'b0;
            o_next_instr  <= 1'b0;
        end else begin
            if (i_return_from_interrupt_instr_instr) begin
                o_nmi_mode <= 1'b0;
            end
            o_irq_service <= i_return_from_interrupt_instr_instr && o_nmi_mode && i_irq_pending;
            o_next_instr  <= i_return_from_interrupt_instr_instr && o_nmi_mode && !i_irq_pending;
        end
    end
    // ==========================================================
    // watchdog
    localparam int WDG_CNT_W_L = rst_wdg_pkg::WDG_CNT_W;
    logic [WDG_CNT_W_L-1:0]   cnt_r;
    logic                     c_r;
    logic [TICK_W-1:0]        tick_r;
    logic [7:0]               wdg_view;
    logic [WDG_CNT_W_L-1:0]   wr_phys;
    logic                     bus_req;
    logic                     wr_wdg;
    logic                     wr_cause;
    logic                     frozen;
    logic                     tick_done;
    logic                     wdg_fire;
    genvar gi;
    generate
        for (gi = 0; gi < rst_wdg_pkg::WDG_T_W; gi++) begin : g_rev
            assign wdg_view[rst_wdg_pkg::WDG_T_BASE + gi] =
                cnt_r[rst_wdg_pkg::WDG_T_W - 1 - gi];
            assign wr_phys[rst_wdg_pkg::WDG_T_W - 1 - gi] =
                i_wb_dat[rst_wdg_pkg::WDG_T_BASE + gi];
        end
    endgenerate
    assign wdg_view[rst_wdg_pkg::WDG_SR_BIT] = cnt_r[WDG_CNT_W_L-1];
    assign wdg_view[rst_wdg_pkg::WDG_C_BIT]  = wdg_en;
    assign wr_phys[WDG_CNT_W_L-1] = i_wb_dat[rst_wdg_pkg::WDG_SR_BIT];
    assign bus_req   = i_wb_cyc && i_wb_stb && !o_wb_ack;
    assign wr_wdg    = bus_req && i_wb_we && i_wb_sel[0] &&
                       i_wb_adr == rst_wdg_pkg::WDG_OFFSET &&
                       state_r == rst_wdg_pkg::ST_RUN;
    assign wr_cause  = bus_req && i_wb_we && i_wb_sel[0] &&
                       i_wb_adr == rst_wdg_pkg::CAUSE_OFFSET;
    assign wdg_en    = i_wdg_hw_option || c_r;
    assign frozen    = o_stop_mode;
    assign tick_done = !frozen && tick_r == TICK_LAST;
    // when disabled the counter is a plain timer; only a write clearing the SR bit can fire
    assign wdg_fire  = state_r == rst_wdg_pkg::ST_RUN &&
                       ((wr_wdg && !i_wb_dat[rst_wdg_pkg::WDG_SR_BIT]) ||
                        (!wr_wdg && wdg_en && tick_done &&
                         cnt_r == rst_wdg_pkg::WDG_CNT_EDGE));

    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n || state_r != rst_wdg_pkg::ST_RUN) begin
            cnt_r  <= rst_wdg_pkg::WDG_CNT_RESET;
            c_r    <= 1'b0;
            tick_r <= '0;
        end else if (wr_wdg) begin
            cnt_r  <= wr_phys;
            c_r    <= c_r | i_wb_dat[rst_wdg_pkg::WDG_C_BIT];
            tick_r <= '0;
        end else if (tick_done) begin
            cnt_r  <= cnt_r - 1'b1;
            tick_r <= '0;
        end else if (!frozen) begin
            tick_r <= tick_r + 1'b1;
        end
    end
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            wdg_hold_r <= '0;
        end else if (wdg_fire) begin
            wdg_hold_r <= HOLD_LOAD;
        end else if (wdg_hold_r != '0) begin
            wdg_hold_r <= wdg_hold_r - 1'b1;
        end
    end
    // ==========================================================
    // reset cause flags and bus slave
    logic [rst_wdg_pkg::CAUSE_W-1:0] cause_r;
    logic [rst_wdg_pkg::CAUSE_W-1:0] cause_set;
    always_comb begin
        cause_set = '0;
        cause_set[rst_wdg_pkg::CAUSE_EXT] = !pin_sync_r && !o_reset_pin_oe;
        cause_set[rst_wdg_pkg::CAUSE_POR] = i_por_active;
        cause_set[rst_wdg_pkg::CAUSE_LVD] = lvd_low_r;
        cause_set[rst_wdg_pkg::CAUSE_WDG] = wdg_fire;
    end
    // set wins over a same-cycle write-one-to-clear
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            cause_r <= '0;
        end else if (wr_cause) begin
            cause_r <= (cause_r & ~i_wb_dat[rst_wdg_pkg::CAUSE_W-1:0])
                       | cause_set;
        end else begin
            cause_r <= cause_r | cause_set;
        end
    end
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= '0;
        end else begin
            o_wb_ack <= bus_req;
            o_wb_dat <= '0;
            if (bus_req && !i_wb_we) begin
                unique case (i_wb_adr)
                    rst_wdg_pkg::WDG_OFFSET:   o_wb_dat <= wdg_view;
                    rst_wdg_pkg::CAUSE_OFFSET: o_wb_dat <= {
                        {(8-rst_wdg_pkg::CAUSE_W){1'b0}}, cause_r};
                    default:                   o_wb_dat <= '0;
                endcase
            end
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_reset_n);

    chk_pin_drive_low: assert property (
        internal_src |=> o_reset_pin_oe && !o_reset_pin_out)
        else $error("internal reset not driven onto pin");
    chk_pin_holds_core: assert property (
        !pin_sync_r |=> o_core_reset [*2])
        else $error("core left reset while pin low");
    chk_lvd_holds_core: assert property (
        lvd_low_r |=> o_core_reset)
        else $error("core ran below voltage threshold");
    chk_stab_before_init: assert property (
        state_r == rst_wdg_pkg::ST_INIT |->
            $past(state_r) == rst_wdg_pkg::ST_STAB &&
            $past(stab_r) == STAB_LAST)
        else $error("init without full stabilisation delay");
    chk_init_vector_load: assert property (
        o_pc_load |-> o_stack_clear &&
            o_pc_value == rst_wdg_pkg::RESET_VECTOR && o_nmi_mode)
        else $error("init did not clear stack or load vector");
    chk_init_then_nmi: assert property (
        $rose(o_pc_load) |=> !o_core_reset && o_nmi_mode)
        else $error("core not released in nmi mode");
    chk_return_from_interrupt_instr_pending: assert property (
        state_r == rst_wdg_pkg::ST_RUN && !any_src && i_return_from_interrupt_instr_instr &&
        o_nmi_mode && i_irq_pending |=> o_irq_service && !o_nmi_mode)
        else $error("pending interrupt not serviced after return");
    chk_sw_reset_bit: assert property (
        wr_wdg && !i_wb_dat[rst_wdg_pkg::WDG_SR_BIT]
        |=> internal_src ##1 o_reset_pin_oe ##1 o_core_reset)
        else $error("clearing software reset bit did not reset");
    chk_stop_freeze_cnt: assert property (
        o_stop_mode && !wr_wdg && state_r == rst_wdg_pkg::ST_RUN
        |=> cnt_r == $past(cnt_r) || !i_reset_n)
        else $error("watchdog counted during stop");
    chk_hw_stop_as_wait: assert property (
        state_nxt == rst_wdg_pkg::ST_RUN && i_stop_instr &&
        i_wdg_hw_option && !i_nmi_pin && !i_wakeup &&
        !o_stop_mode && !o_wait_mode |=> o_wait_mode && !o_stop_mode)
        else $error("stop not turned into wait");
    chk_reload_value: assert property (
        wr_wdg |=> cnt_r == $past(wr_phys) ||
            state_r != rst_wdg_pkg::ST_RUN)
        else $error("watchdog reload lost");
    chk_periph_values: assert property (
        o_core_reset |-> o_periph_init == rst_wdg_pkg::PERIPH_INIT)
        else $error("peripheral reset values wrong");

    cov_wdg_timeout: cover property (
        wdg_fire && !wr_wdg);
    cov_stop_entry: cover property (
        $rose(o_stop_mode));
    cov_init_pass: cover property (
        $rose(o_pc_load) ##1 !o_core_reset);
endmodule

// ==== verif/reset_board_model.sv ====
`timescale 1ns/1ps
// ==========================================================
// board side of the reset line: pull-up plus wired-and
module reset_board_model (
    input  wire logic i_ext_low,
    input  wire logic i_pin_oe,
    output logic      o_pin_n
);
    // pull-up wins only while nobody pulls low; a real pin would
    // also show slow edges, which this model leaves out
    assign o_pin_n = !(i_ext_low || i_pin_oe);
endmodule

// ==== verif/mcu_reset_and_watchdog_control_test.sv ====
`timescale 1ns/1ps
module mcu_reset_and_watchdog_control_test;
    // ==========================================================
    // wiring
    localparam int STAB_N = 8;
    logic i_core_clk = 1'h0, i_reset_n = 1'h0, ext_low = 1'h0;
    logic i_reset_pin_in_n, i_por_active = 1'h0, i_lvd_enable = 1'h0;
    logic i_vdd_above_rise = 1'h1, i_vdd_above_fall = 1'h1;
    logic i_osc_running = 1'h1, i_wdg_hw_option = 1'h0;
    logic i_ext_stop_option = 1'h0, i_nmi_pin = 1'h0;
    logic i_stop_instr = 1'h0, i_wait_instr = 1'h0, i_wakeup = 1'h0;
    logic i_return_from_interrupt_instr_instr = 1'h0, i_irq_pending = 1'h0;
    logic i_wb_cyc = 1'h0, i_wb_stb = 1'h0, i_wb_we = 1'h0;
    logic [7:0] i_wb_adr = 8'h00, i_wb_dat = 8'h00, o_wb_dat, rd;
    logic [0:0] i_wb_sel = 1'h1;
    logic o_wb_ack, o_reset_pin_out, o_reset_pin_oe, o_core_reset;
    logic o_io_pullup, o_osc_enable, o_stop_mode, o_wait_mode;
    logic o_stack_clear, o_pc_load, o_nmi_mode, o_irq_service;
    logic o_next_instr;
    logic [11:0] o_pc_value;
    rst_wdg_pkg::periph_init_s o_periph_init;
    int fail_count = 0, checks_done = 0, t, i;
    reset_watchdog_ctrl #(.WDG_TICK(4), .STAB(STAB_N), .PIN_HOLD(3)) dut (
        .i_core_clk, .i_reset_n, .i_reset_pin_in_n, .i_por_active,
        .i_lvd_enable, .i_vdd_above_rise, .i_vdd_above_fall,
        .i_osc_running, .i_wdg_hw_option, .i_ext_stop_option, .i_nmi_pin,
        .i_stop_instr, .i_wait_instr, .i_wakeup, .i_return_from_interrupt_instr_instr,
        .i_irq_pending, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr,
        .i_wb_dat, .i_wb_sel, .o_wb_dat, .o_wb_ack, .o_reset_pin_out,
        .o_reset_pin_oe, .o_core_reset, .o_io_pullup, .o_osc_enable,
        .o_stop_mode, .o_wait_mode, .o_stack_clear, .o_pc_load,
        .o_pc_value, .o_nmi_mode, .o_irq_service, .o_next_instr,
        .o_periph_init);
    reset_board_model board (.i_ext_low(ext_low),
        .i_pin_oe(o_reset_pin_oe), .o_pin_n(i_reset_pin_in_n));
    always #2.5 i_core_clk = ~i_core_clk;
    // ==========================================================
    // helpers
    task automatic check(input string what, input logic [63:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    function automatic logic sig(input int k);
        case (k)
            0: return o_pc_load;
            1: return o_reset_pin_oe;
            2: return o_core_reset;
            3: return o_stop_mode;
            4: return o_wait_mode;
            5: return o_irq_service;
            default: return o_next_instr;
        endcase
    endfunction
    // bounded wait; t is the number of edges it took
    task automatic wait_for(input int k, input int n);
        for (t = 1; t <= n; t++) begin
            @(posedge i_core_clk);
            #1;
            if (sig(k) === 1'h1) return;
        end
        fail_count++;
        $display("wrong value wait %0d expected 1 seen 0", k);
        wrap_up();
    endtask
    task automatic booted();
        wait_for(0, 400);
        check("stack_clear", o_stack_clear, 1'h1);
        check("pc_value", o_pc_value, 12'hffe);
        // core leaves reset one edge after the init pulse
        @(posedge i_core_clk);
        #1;
        check("core_reset", o_core_reset, 1'h0);
        check("nmi_mode", o_nmi_mode, 1'h1);
    endtask
    // classic cycle: hold until ack is sampled, then release
    task automatic wb(input logic we, input logic [7:0] adr, wd);
        @(posedge i_core_clk);
        {i_wb_cyc, i_wb_stb, i_wb_we} <= {2'h3, we};
        {i_wb_adr, i_wb_dat} <= {adr, wd};
        for (i = 0; i < 20 && o_wb_ack !== 1'h1; i++) begin
            @(posedge i_core_clk);
        end
        rd = o_wb_dat;
        {i_wb_cyc, i_wb_stb, i_wb_we} <= 3'h0;
        if (i == 20) begin
            check("ack", 1'h0, 1'h1);
            wrap_up();
        end
    endtask
    // strobes {stop, wait, wakeup, return_from_interrupt_instr} for one cycle
    task automatic pulse(input logic [3:0] v);
        @(posedge i_core_clk);
        {i_stop_instr, i_wait_instr, i_wakeup, i_return_from_interrupt_instr_instr} <= v;
        @(posedge i_core_clk);
        {i_stop_instr, i_wait_instr, i_wakeup, i_return_from_interrupt_instr_instr} <= 4'h0;
    endtask
    // ==========================================================
    // register rows: we, address, write data, read mask, expected
    logic [32:0] rows [8] = '{
        {1'h0, 8'hd8, 8'h00, 8'h03, 8'h02}, {1'h1, 8'h10, 8'h55, 16'h0},
        {1'h0, 8'h10, 8'h00, 8'hff, 8'h00}, {1'h1, 8'hd8, 8'hff, 16'h0},
        {1'h1, 8'hd8, 8'hfe, 16'h0}, {1'h0, 8'hd8, 8'h00, 8'h01, 8'h01},
        {1'h1, 8'hf0, 8'h0f, 16'h0}, {1'h0, 8'hf0, 8'h00, 8'hff, 8'h00}};
    // option rows: hardware, external stop, nmi, true stop expected
    logic [3:0] modes [4] = '{4'h1, 4'h8, 4'hf, 4'hc};
    initial begin
        repeat (12) @(posedge i_core_clk);
        i_reset_n <= 1'h1;
        booted();
        check("periph", o_periph_init, 56'h02ff7f00000000);
        foreach (rows[r]) begin
            wb(rows[r][32], rows[r][31:24], rows[r][23:16]);
            check("reg", rd & rows[r][15:8], rows[r][7:0]);
        end
        for (int n = 0; n < 6; n++) begin
            repeat (100) @(posedge i_core_clk);
            wb(1'h1, 8'hd8, 8'hff);
            check("reload", o_reset_pin_oe, 1'h0);
        end
        wait_for(1, 600);
        check("wdg late", t > 200, 1'h1);
        wait_for(2, 5);
        booted();
        wb(1'h0, 8'hd8, 8'h00);
        check("c after", rd & 8'h01, 8'h00);
        wb(1'h0, 8'hf0, 8'h00);
        check("cause wdg", rd & 8'h08, 8'h08);
        wb(1'h1, 8'hd8, 8'h01);
        wait_for(1, 5);
        booted();
        foreach (modes[m]) begin
            {i_wdg_hw_option, i_ext_stop_option, i_nmi_pin} <= modes[m][3:1];
            if (m > 0) wb(1'h1, 8'hd8, 8'hff);
            pulse(4'h8);
            wait_for(modes[m][0] ? 3 : 4, 4);
            check("osc", o_osc_enable, !modes[m][0]);
            pulse(4'h2);
            repeat (2) @(posedge i_core_clk);
            check("awake", {o_stop_mode, o_wait_mode}, 2'h0);
        end
        i_wdg_hw_option <= 1'h0;
        ext_low <= 1'h1;
        repeat (2) @(posedge i_core_clk);
        ext_low <= 1'h0;
        wait_for(2, 8);
        booted();
        ext_low <= 1'h1;
        wait_for(2, 8);
        repeat (20) @(posedge i_core_clk) begin
            check("held", {o_core_reset, o_io_pullup}, 2'h3);
        end
        ext_low <= 1'h0;
        booted();
        i_irq_pending <= 1'h1;
        pulse(4'h1);
        // service pulse stands for one cycle only
        #1;
        check("irq_service", o_irq_service, 1'h1);
        check("nmi left", o_nmi_mode, 1'h0);
        {i_lvd_enable, i_vdd_above_rise, i_vdd_above_fall} <= 3'h4;
        i_irq_pending <= 1'h0;
        wait_for(1, 5);
        i_vdd_above_fall <= 1'h1;
        repeat (20) @(posedge i_core_clk);
        check("lvd hyst", o_core_reset, 1'h1);
        i_vdd_above_rise <= 1'h1;
        booted();
        i_vdd_above_rise <= 1'h0;
        repeat (30) @(posedge i_core_clk);
        check("lvd run", o_core_reset, 1'h0);
        pulse(4'h1);
        #1;
        check("next_instr", o_next_instr, 1'h1);
        {i_por_active, i_osc_running} <= 2'h2;
        wait_for(1, 5);
        check("por pullup", o_io_pullup, 1'h1);
        i_por_active <= 1'h0;
        repeat (30) @(posedge i_core_clk);
        check("osc wait", {o_core_reset, o_pc_load}, 2'h2);
        i_osc_running <= 1'h1;
        wait_for(0, 100);
        check("stab", t == STAB_N + 1, 1'h1);
        wrap_up();
    end
endmodule
